// *** rtl/banked_map_pkg.sv ***
// Constants for the banked data memory map and its core register set.
package banked_map_pkg;
  localparam int unsigned ADDR_W        = 12;
  localparam int unsigned BANK_W        = 5;
  localparam int unsigned OFS_W         = 7;
  localparam int unsigned LIN_W         = 16;
  localparam int unsigned NUM_BANKS     = 32;
  localparam int unsigned GPR_PER_BANK  = 80;
  localparam int unsigned COMMON_BYTES  = 16;
  localparam int unsigned PERIPH_BYTES  = 20;

  localparam logic [6:0] OFS_IND0     = 7'h00;
  localparam logic [6:0] OFS_IND1     = 7'h01;
  localparam logic [6:0] OFS_PCL      = 7'h02;
  localparam logic [6:0] OFS_STATUS   = 7'h03;
  localparam logic [6:0] OFS_PTR0_LO  = 7'h04;
  localparam logic [6:0] OFS_PTR0_HI  = 7'h05;
  localparam logic [6:0] OFS_PTR1_LO  = 7'h06;
  localparam logic [6:0] OFS_PTR1_HI  = 7'h07;
  localparam logic [6:0] OFS_BANK_SEL = 7'h08;
  localparam logic [6:0] OFS_WACC     = 7'h09;
  localparam logic [6:0] OFS_PCH_LAT  = 7'h0A;
  localparam logic [6:0] OFS_INTCTL   = 7'h0B;
  localparam logic [6:0] OFS_CORE_END = 7'h0B;
  localparam logic [6:0] OFS_PER_LO   = 7'h0C;
  localparam logic [6:0] OFS_PER_HI   = 7'h1F;
  localparam logic [6:0] OFS_GPR_LO   = 7'h20;
  localparam logic [6:0] OFS_GPR_HI   = 7'h6F;
  localparam logic [6:0] OFS_COM_LO   = 7'h70;

  localparam logic [4:0] BANK_REMAP_LO = 5'h1B;
  localparam logic [4:0] BANK_REMAP_HI = 5'h1D;

  // Linear window through which indirect pointers see all general RAM contiguously.
  localparam logic [15:0] LIN_BASE = 16'h2000;
  localparam logic [15:0] LIN_SIZE = 16'h0A00;

  localparam logic [7:0] RST_STATUS = 8'h18;
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] RST_INTCTL = 8'h01;
  localparam logic [7:0] MASK_STATUS_WR = 8'h07;
  localparam logic [7:0] MASK_STATUS_RD = 8'h1F;
  localparam logic [7:0] MASK_BANK      = 8'h1F;
  localparam logic [7:0] MASK_PCH       = 8'h7F;
  localparam logic [7:0] MASK_INTCTL    = 8'hC1;

  typedef enum logic [2:0] {
    REG_CORE,
    REG_PERIPH,
    REG_REMAP,
    REG_GPR,
    REG_COMMON,
    REG_NONE
  } region_t;
endpackage

// *** rtl/linear_ram_map.sv ***
// Maps a linear pointer address onto one general-RAM index and flags whether it hits the linear window.
`timescale 1ns/10ps
module linear_ram_map
  import banked_map_pkg::*;
(
  input  wire logic [15:0] i_lin_addr,
  output logic             o_hit,
  output logic [11:0]      o_index
);
  logic [15:0] rel;

  always_comb begin
    rel     = i_lin_addr - LIN_BASE;
    o_hit   = (i_lin_addr >= LIN_BASE) && (rel < LIN_SIZE);
    o_index = rel[11:0];
  end
endmodule

// *** rtl/bank_region_decode.sv ***
// Classifies a 12-bit data address into its memory region.
`timescale 1ns/10ps
module bank_region_decode
  import banked_map_pkg::*;
(
  input  wire logic [11:0] i_addr,
  output region_t          o_region,
  output logic [11:0]      o_gpr_linear
);
  logic [4:0]  bank;
  logic [6:0]  ofs;
  logic [11:0] gpr_rel;

  always_comb begin
    bank    = i_addr[11:7];
    ofs     = i_addr[6:0];
    gpr_rel = {5'h00, ofs - OFS_GPR_LO};
    o_gpr_linear = 12'(bank * GPR_PER_BANK) + gpr_rel;
    if (ofs <= OFS_CORE_END) begin
      o_region = REG_CORE;
    end else if (ofs <= OFS_PER_HI) begin
      if (bank >= BANK_REMAP_LO && bank <= BANK_REMAP_HI) begin
        o_region = REG_REMAP;
      end else begin
        o_region = REG_PERIPH;
      end
    end else if (ofs <= OFS_GPR_HI) begin
      o_region = REG_GPR;
    end else begin
      o_region = REG_COMMON;
    end
  end
endmodule

// *** rtl/banked_data_memory_map.sv ***
// Banked data memory decoder with core registers, general RAM and common RAM.
// Operation
// - Offsets 0Ch-1Fh of each bank go to the peripheral register window.
// - Banks 27-29 route that window to remapping and logic cell registers.
// - Every bank holds 80 bytes of general RAM.
// - Indirect pointers reach all general RAM as one contiguous linear block.
// - Sixteen common RAM bytes are the same in every bank.
// - Core registers 00h-0Bh appear identically in all 32 banks.
// - Port 0 accesses the location held by pointer 0.
// - Port 1 accesses the location held by pointer 1.
// - Offset 02h shows program counter low byte; resets to zero.
// - Offset 0Ah buffers upper 7 counter bits until a counter load.
// - Direct addresses are 12 bits: five bank bits, seven offset bits.
// - Direct accesses use the bank last written into bank select.
// - Unimplemented locations read as zero.
`timescale 1ns/10ps
module banked_data_memory_map
  import banked_map_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic [6:0]  i_ofs,
  input  wire logic        i_rd,
  input  wire logic        i_wr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_pc_load,
  input  wire logic        i_pc_step,
  input  wire logic [7:0]  i_alu_flags,
  input  wire logic        i_alu_flags_we,
  input  wire logic [7:0]  i_periph_rdata,
  output logic [7:0]       o_rdata,
  output logic [14:0]      o_program_counter,
  output logic [4:0]       o_bank,
  output logic             o_periph_rd,
  output logic             o_periph_wr,
  output logic             o_remap_sel,
  output logic [11:0]      o_periph_addr,
  output logic [7:0]       o_periph_wdata
);
  localparam int unsigned RAM_BYTES = NUM_BANKS * GPR_PER_BANK;

  logic [7:0]  ram_ff [RAM_BYTES];
  logic [7:0]  com_ff [COMMON_BYTES];
  logic [14:0] pc_ff, nxt_pc;
  logic [7:0]  status_ff, nxt_status;
  logic [7:0]  p0l_ff, nxt_p0l, p0h_ff, nxt_p0h;
  logic [7:0]  p1l_ff, nxt_p1l, p1h_ff, nxt_p1h;
  logic [7:0]  bank_ff, nxt_bank;
  logic [7:0]  wacc_ff, nxt_wacc;
  logic [7:0]  pch_ff, nxt_pch;
  logic [7:0]  intctl_ff, nxt_intctl;
  logic [7:0]  rdata_ff, nxt_rdata;

  logic        is_ind;
  logic [15:0] ptr;
  logic [11:0] eff_addr;
  logic        lin_hit;
  logic [11:0] lin_idx;
  region_t     region;
  logic [11:0] gpr_idx;
  logic [6:0]  eofs;
  logic        ram_we, com_we, core_we;
  logic [11:0] ram_idx;
  logic [7:0]  core_rd;
  logic        ptr_far;

  // Pointer selection: ports 0 and 1 redirect to their pointer pairs.
  always_comb begin
    is_ind = (i_ofs == OFS_IND0) || (i_ofs == OFS_IND1);
    ptr    = (i_ofs == OFS_IND1) ? {p1h_ff, p1l_ff} : {p0h_ff, p0l_ff};
    // Pointer targeting a port yields a null access rather than recursion.
    eff_addr = is_ind ? ptr[11:0] : {bank_ff[4:0], i_ofs};
  end

  linear_ram_map u_lin (
    .i_lin_addr (ptr),
    .o_hit      (lin_hit),
    .o_index    (lin_idx)
  );

  bank_region_decode u_dec (
    .i_addr       (eff_addr),
    .o_region     (region),
    .o_gpr_linear (gpr_idx)
  );

  // A pointer with its high nibble set never lands in the banked map; only the linear
  // window may still claim it, so every banked strobe is cut for such a pointer.
  always_comb begin
    ptr_far = is_ind && (ptr[15:12] != 4'h0);
    eofs    = eff_addr[6:0];
    ram_idx = (is_ind && lin_hit) ? lin_idx : gpr_idx;
    ram_we  = i_wr && ((is_ind && lin_hit) || (!ptr_far && region == REG_GPR));
    com_we  = i_wr && !ptr_far && region == REG_COMMON;
    core_we = i_wr && !ptr_far && region == REG_CORE
              && !(eofs == OFS_IND0 || eofs == OFS_IND1);
  end

  // Counter group: the high latch reaches the counter only on a load or a low-byte write.
  always_comb begin
    nxt_pc = pc_ff;
    if (i_pc_step) begin
      nxt_pc = pc_ff + 15'h0001;
    end
    if (i_pc_load) begin
      nxt_pc = {pch_ff[6:0], pc_ff[7:0]};
    end
    if (core_we && eofs == OFS_PCL) begin
      // Writing the low byte also pulls in the latched upper bits, as a computed jump.
      nxt_pc = {pch_ff[6:0], i_wdata};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pc_ff <= '0;
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  // Latch group: a write here only parks the upper bits until the counter takes them.
  always_comb begin
    nxt_pch = pch_ff;
    if (core_we && eofs == OFS_PCH_LAT) begin
      nxt_pch = i_wdata & MASK_PCH;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pch_ff <= RST_ZERO;
    end else begin
      pch_ff <= nxt_pch;
    end
  end

  // Pointer 0 pair: written byte by byte, used as one 16-bit address.
  always_comb begin
    nxt_p0l = p0l_ff;
    nxt_p0h = p0h_ff;
    if (core_we && eofs == OFS_PTR0_LO) begin
      nxt_p0l = i_wdata;
    end
    if (core_we && eofs == OFS_PTR0_HI) begin
      nxt_p0h = i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      p0l_ff <= RST_ZERO;
      p0h_ff <= RST_ZERO;
    end else begin
      p0l_ff <= nxt_p0l;
      p0h_ff <= nxt_p0h;
    end
  end

  // Pointer 1 pair: written byte by byte, used as one 16-bit address.
  always_comb begin
    nxt_p1l = p1l_ff;
    nxt_p1h = p1h_ff;
    if (core_we && eofs == OFS_PTR1_LO) begin
      nxt_p1l = i_wdata;
    end
    if (core_we && eofs == OFS_PTR1_HI) begin
      nxt_p1h = i_wdata;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      p1l_ff <= RST_ZERO;
      p1h_ff <= RST_ZERO;
    end else begin
      p1l_ff <= nxt_p1l;
      p1h_ff <= nxt_p1h;
    end
  end

  // Flags group: a result from the arithmetic unit wins over a software write in the
  // same cycle, so the write never hides a flag that was just computed.
  always_comb begin
    nxt_status = status_ff;
    if (core_we && eofs == OFS_STATUS) begin
      nxt_status = (status_ff & ~MASK_STATUS_WR) | (i_wdata & MASK_STATUS_WR);
    end
    if (i_alu_flags_we) begin
      nxt_status = (status_ff & ~MASK_STATUS_WR) | (i_alu_flags & MASK_STATUS_WR);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      status_ff <= RST_STATUS;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // Bank group: only the low five bits are kept; the upper bits read back as zero.
  always_comb begin
    nxt_bank = bank_ff;
    if (core_we && eofs == OFS_BANK_SEL) begin
      nxt_bank = i_wdata & MASK_BANK;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      bank_ff <= RST_ZERO;
    end else begin
      bank_ff <= nxt_bank;
    end
  end

  // Remaining core registers: accumulator and interrupt control, one physical copy each.
  always_comb begin
    nxt_wacc   = wacc_ff;
    nxt_intctl = intctl_ff;
    if (core_we && eofs == OFS_WACC) begin
      nxt_wacc = i_wdata;
    end
    if (core_we && eofs == OFS_INTCTL) begin
      nxt_intctl = i_wdata & MASK_INTCTL;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      wacc_ff   <= RST_ZERO;
      intctl_ff <= RST_INTCTL;
    end else begin
      wacc_ff   <= nxt_wacc;
      intctl_ff <= nxt_intctl;
    end
  end

  always_comb begin
    unique case (eofs[3:0])
      OFS_PCL[3:0]:      core_rd = pc_ff[7:0];
      OFS_STATUS[3:0]:   core_rd = status_ff & MASK_STATUS_RD;
      OFS_PTR0_LO[3:0]:  core_rd = p0l_ff;
      OFS_PTR0_HI[3:0]:  core_rd = p0h_ff;
      OFS_PTR1_LO[3:0]:  core_rd = p1l_ff;
      OFS_PTR1_HI[3:0]:  core_rd = p1h_ff;
      OFS_BANK_SEL[3:0]: core_rd = bank_ff;
      OFS_WACC[3:0]:     core_rd = wacc_ff;
      OFS_PCH_LAT[3:0]:  core_rd = pch_ff;
      OFS_INTCTL[3:0]:   core_rd = intctl_ff;
      default:           core_rd = RST_ZERO;
    endcase
  end

  // Read data registered; unmapped pointer targets and empty regions return zero.
  always_comb begin
    nxt_rdata = rdata_ff;
    if (i_rd) begin
      if (is_ind && lin_hit) begin
        nxt_rdata = ram_ff[ram_idx];
      end else if (is_ind && ptr[15:12] != 4'h0) begin
        nxt_rdata = RST_ZERO;
      end else begin
        unique case (region)
          REG_CORE:   nxt_rdata = core_rd;
          REG_PERIPH: nxt_rdata = i_periph_rdata;
          REG_REMAP:  nxt_rdata = i_periph_rdata;
          REG_GPR:    nxt_rdata = ram_ff[ram_idx];
          REG_COMMON: nxt_rdata = com_ff[eofs[3:0]];
          default:    nxt_rdata = RST_ZERO;
        endcase
      end
    end
  end

  always_comb begin
    o_periph_rd    = i_rd && !(is_ind && ptr[15:12] != 4'h0)
                     && (region == REG_PERIPH || region == REG_REMAP);
    o_periph_wr    = i_wr && !(is_ind && ptr[15:12] != 4'h0)
                     && (region == REG_PERIPH || region == REG_REMAP);
    o_remap_sel    = (region == REG_REMAP);
    o_periph_addr  = eff_addr;
    o_periph_wdata = i_wdata;
    o_rdata        = rdata_ff;
    o_program_counter = pc_ff;
    o_bank         = bank_ff[4:0];
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rdata_ff <= RST_ZERO;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // RAM arrays carry no reset so they map onto plain memory.
  always_ff @(posedge i_sys_clk) begin
    if (ram_we) begin
      ram_ff[ram_idx] <= i_wdata;
    end
    if (com_we) begin
      com_ff[eofs[3:0]] <= i_wdata;
    end
  end
endmodule

// *** test/periph_window_model.sv ***
// Peripheral register window model answering reads combinationally.
`timescale 1ns/10ps
module periph_window_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rd,
  input  wire logic [11:0] i_addr,
  output logic [7:0]       o_rdata
);
  // Between reads the bus toggles, so sampling it at the wrong moment shows up.
  logic [7:0] idle_ff = 8'h3C;
  always @(posedge i_sys_clk) begin
    idle_ff <= ~idle_ff;
  end
  assign o_rdata = i_rd ? (i_addr[7:0] ^ 8'hA5) : idle_ff;
endmodule

// *** test/mem_map_chk.sv ***
// Port-level assertions for the banked data memory decoder.
`timescale 1ns/10ps
module mem_map_chk
  import banked_map_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_rst_n,
  input wire logic [6:0]  i_ofs,
  input wire logic        i_rd,
  input wire logic        i_wr,
  input wire logic [7:0]  i_wdata,
  input wire logic        i_pc_load,
  input wire logic        i_pc_step,
  input wire logic [7:0]  i_periph_rdata,
  input wire logic [7:0]  o_rdata,
  input wire logic [14:0] o_program_counter,
  input wire logic [4:0]  o_bank,
  input wire logic        o_periph_rd,
  input wire logic        o_periph_wr,
  input wire logic        o_remap_sel,
  input wire logic [11:0] o_periph_addr
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic win;
  assign win = i_ofs inside {[OFS_PER_LO:OFS_PER_HI]};
  sequence s_bank_wr;
    i_wr && i_ofs == OFS_BANK_SEL;
  endsequence
  sequence s_latch_wr;
    i_wr && i_ofs == OFS_PCH_LAT && !i_pc_load && !i_pc_step;
  endsequence
  periph_strobe_a: assert property (win |-> o_periph_rd == i_rd && o_periph_wr == i_wr)
    else $error("window strobe wrong");
  periph_quiet_a: assert property (i_ofs > OFS_PER_HI |-> !o_periph_rd && !o_periph_wr)
    else $error("strobe outside window");
  remap_sel_a: assert property (win |-> o_remap_sel == (o_bank inside {[BANK_REMAP_LO:BANK_REMAP_HI]}))
    else $error("remap select wrong");
  direct_addr_a: assert property ((i_rd || i_wr) && i_ofs > OFS_IND1 |-> o_periph_addr == {o_bank, i_ofs})
    else $error("direct address wrong");
  bank_write_a: assert property (s_bank_wr |=> o_bank == $past(i_wdata[4:0]))
    else $error("bank not written");
  bank_hold_a: assert property (!i_wr |=> $stable(o_bank))
    else $error("bank changed");
  latch_only_a: assert property (s_latch_wr |=> $stable(o_program_counter))
    else $error("latch write moved counter");
  pc_step_a: assert property (i_pc_step && !i_pc_load && !i_wr |=> o_program_counter == $past(o_program_counter) + 15'h0001)
    else $error("counter step wrong");
  reset_val_a: assert property ($rose(i_rst_n) |-> o_program_counter == 15'h0000 && o_bank == 5'h00 && o_rdata == 8'h00)
    else $error("reset values wrong");
  periph_data_a: assert property (i_rd && win |=> o_rdata == $past(i_periph_rdata))
    else $error("window read data wrong");
endmodule
bind banked_data_memory_map mem_map_chk i_chk (.*);

// *** test/tb.sv ***
// Self-checking testbench for the banked data memory decoder.
`timescale 1ns/10ps
module tb
  import banked_map_pkg::*;
;
  logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_rd = 1'b0, i_wr = 1'b0, i_pc_load = 1'b0, i_pc_step = 1'b0;
  logic i_alu_flags_we = 1'b0, rd_seen = 1'b0, o_periph_rd, o_periph_wr, o_remap_sel;
  logic [6:0] i_ofs = 7'h00, o;
  logic [7:0] i_wdata = 8'h00, i_alu_flags = 8'h00, i_periph_rdata, o_rdata, o_periph_wdata, d;
  logic [14:0] o_program_counter;
  logic [4:0] o_bank, b;
  logic [11:0] o_periph_addr;
  logic [7:0] exp_q[$];
  int fail_count = 0, n_tests = 0, seed = 32'h9EF8C093;
  banked_data_memory_map i_dut (.*);
  periph_window_model i_per (.i_sys_clk(i_sys_clk), .i_rd(o_periph_rd), .i_addr(o_periph_addr), .o_rdata(i_periph_rdata));
  initial begin
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  task automatic check(input string name, input logic [14:0] seen, input logic [14:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic acc(input logic w, input logic [6:0] ofs, input logic [7:0] data);
    @(posedge i_sys_clk);
    i_ofs <= ofs;
    i_wr <= w;
    i_rd <= !w;
    i_wdata <= data;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] ofs, input logic [7:0] exp);
    exp_q.push_back(exp);
    acc(1'b0, ofs, 8'h00);
  endtask
  task automatic ptr(input logic [6:0] lo, input logic [15:0] p);
    acc(1'b1, lo, p[7:0]);
    acc(1'b1, lo + 7'h01, p[15:8]);
  endtask
  // Read data is registered at the taking edge itself, so it is judged at the following falling edge.
  always @(posedge i_sys_clk) rd_seen <= i_rd;
  always @(negedge i_sys_clk) begin
    if (rd_seen) check("read data", {7'h00, o_rdata}, {7'h00, exp_q.pop_front()});
    if (o_periph_wr) check("window write", {7'h00, o_periph_wdata}, {7'h00, i_wdata});
  end
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    fail_count++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    for (int k = 2; k < 12; k++) rd(7'(k), k == 3 ? 8'h18 : k == 11 ? 8'h01 : 8'h00);
    acc(1'b1, OFS_BANK_SEL, 8'hFF);
    rd(OFS_BANK_SEL, 8'h1F);
    for (int k = 26; k < 31; k++) begin
      acc(1'b1, OFS_BANK_SEL, 8'(k));
      o = k[0] ? OFS_PER_HI : OFS_PER_LO;
      rd(o, {k[0], o} ^ 8'hA5);
      acc(1'b1, o, 8'(k));
    end
    acc(1'b1, OFS_BANK_SEL, 8'h03);
    acc(1'b1, 7'h25, 8'hAA);
    acc(1'b1, OFS_COM_LO, 8'h5C);
    acc(1'b1, OFS_WACC, 8'h77);
    rd(7'h25, 8'hAA);
    acc(1'b1, OFS_BANK_SEL, 8'h1E);
    rd(OFS_COM_LO, 8'h5C);
    rd(OFS_WACC, 8'h77);
    ptr(OFS_PTR0_LO, 16'h20F5);
    rd(OFS_IND0, 8'hAA);
    ptr(OFS_PTR1_LO, 16'h01A5);
    rd(OFS_IND1, 8'hAA);
    acc(1'b1, OFS_BANK_SEL, 8'h01);
    acc(1'b1, OFS_GPR_LO, 8'h3E);
    ptr(OFS_PTR1_LO, 16'h2050);
    rd(OFS_IND1, 8'h3E);
    ptr(OFS_PTR0_LO, 16'h2A00);
    rd(OFS_IND0, 8'h00);
    ptr(OFS_PTR0_LO, 16'h3000);
    rd(OFS_IND0, 8'h00);
    acc(1'b1, OFS_STATUS, 8'hFF);
    rd(OFS_STATUS, 8'h1F);
    i_alu_flags <= 8'h02;
    i_alu_flags_we <= 1'b1;
    acc(1'b1, OFS_STATUS, 8'h00);
    i_alu_flags_we <= 1'b0;
    rd(OFS_STATUS, 8'h1A);
    acc(1'b1, OFS_PCH_LAT, 8'h85);
    #1 check("counter", o_program_counter, 15'h0000);
    @(posedge i_sys_clk);
    i_pc_load <= 1'b1;
    @(posedge i_sys_clk);
    i_pc_load <= 1'b0;
    i_pc_step <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_pc_step <= 1'b0;
    rd(OFS_PCL, 8'h03);
    #1 check("counter", o_program_counter, 15'h0503);
    acc(1'b1, OFS_PCL, 8'h34);
    #1 check("counter", o_program_counter, 15'h0534);
    repeat (6) begin
      b = 5'($random(seed));
      o = OFS_GPR_LO + 7'($unsigned($random(seed)) % 80);
      d = 8'($random(seed));
      acc(1'b1, OFS_BANK_SEL, {3'h0, b});
      acc(1'b1, o, d);
      rd(o, d);
      ptr(OFS_PTR0_LO, 16'h2000 + 16'(b) * 16'h0050 + 16'(o) - 16'h0020);
      rd(OFS_IND0, d);
    end
    @(posedge i_sys_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rd(OFS_PCL, 8'h00);
    rd(OFS_BANK_SEL, 8'h00);
    #1 check("counter", o_program_counter, 15'h0000);
    repeat (4) @(posedge i_sys_clk);
    stop_test();
  end
endmodule
